// ==== pkg/cflt_defs.svh ====
// constants for the can filter and bit timing block
`ifndef CFLT_DEFS_SVH
`define CFLT_DEFS_SVH
`define CFLT_OFS_TALLY      12'h000
`define CFLT_OFS_TIM1       12'h004
`define CFLT_OFS_TIM2       12'h008
`define CFLT_OFS_TIM3       12'h00c
`define CFLT_OFS_CTRL       12'h010
`define CFLT_OFS_STAT       12'h014
`define CFLT_OFS_FILT_BASE  12'h100
`define CFLT_OFS_MASK_BASE  12'h200
`define CFLT_PASSIVE_LIMIT  8'h7f
`define CFLT_SIDL_KEEP_F    8'heb
`define CFLT_SIDL_KEEP_M    8'he3
`define CFLT_EXTSEL_BIT     3
`define CFLT_TIM3_KEEP      8'h47
`define CFLT_IPT_TQ         4'h2
`define CFLT_HIT_NONE       3'h7
`endif

// ==== pkg/cflt_pkg.sv ====
// types of the can filter and bit timing block
package cflt_pkg;
    typedef struct packed {
        logic [1:0] sjw;
        logic [5:0] brp;
    } cflt_tim1_s;
    typedef struct packed {
        logic       ph2_src;
        logic       triple;
        logic [2:0] ph1;
        logic [2:0] prop;
    } cflt_tim2_s;
    typedef struct packed {
        logic       rsv7;
        logic       wake_filt;
        logic [2:0] rsv;
        logic [2:0] ph2;
    } cflt_tim3_s;
    typedef enum logic [1:0] {
        CFLT_SYNC = 2'b00,
        CFLT_PROP = 2'b01,
        CFLT_PH1  = 2'b11,
        CFLT_PH2  = 2'b10
    } cflt_seg_e;
endpackage

// ==== rtl/cflt_core.sv ====
// can acceptance filters, error tally and bit timing core
`timescale 1ns/100ps
`default_nettype none
`include "cflt_defs.svh"

// Summary of operation
// RL1: 8-bit receive tally readable; error passive above 127.
// RL2: receive tally alone never drives bus-off.
// RL3: filter high byte matches std id 10..3 or ext id 28..21.
// RL4: low byte bits 7..5 are std 2..0 or ext 20..18.
// RL5: extended select bit 3 chooses extended-only or standard-only acceptance.
// RL6: low byte bits 1..0 are ext 17..16; two bytes hold ext 15..0.
// RL7: filter low byte bits 4 and 2 read zero.
// RL8: masks share the filter layout without an extended select.
// RL9: mask low byte bits 4..2 read zero.
// RL10: quantum lasts 2*(prescaler+1) clock periods.
// RL11: jump width is field plus one quanta.
// RL12: software writes timing only in configuration mode.
// RL13: phase 2 is max(phase1, processing time) unless freely programmable.
// RL14: triple sample select takes three samples, else one.
// RL15: phase 1 is field plus one quanta.
// RL16: propagation is field plus one quanta.
// RL17: phase 2 is field plus one quanta when programmable.
// RL18: phase 2 field ignored while source select clear.
// RL19: wake filter select passes bus line through a filter.
// RL20: timing registers reset zero; filter and mask bits unset.
// RL21: hit code 0..5 names admitting filter; 6 and 7 reserved.
// RL22: compare only where mask bit is one.
// RL23: bit is sync plus prop, phase1, phase2; sample ends phase 1.
module cflt_core #(
    parameter int NFILT = 6,
    parameter int NMASK = 2
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        RX_LINE,
    input  wire logic        RX_ERR_INC,
    input  wire logic        RX_ERR_BIG,
    input  wire logic        RX_OK_DEC,
    input  wire logic        ID_VALID,
    input  wire logic        ID_EXT,
    input  wire logic [28:0] ID_VALUE,
    output logic             ERROR_PASSIVE,
    output logic             BUS_OFF_FROM_RX,
    output logic [2:0]       ACCEPTANCE_HIT_CODE,
    output logic             ACCEPT_VALID,
    output logic             TQ_TICK,
    output logic             SAMPLE_POINT,
    output logic             SAMPLED_BIT,
    output logic             WAKE_LINE,
    output logic [2:0]       RESYNC_JUMP_WIDTH
);
    // ================================================================
    // registers
    logic [7:0]  rx_error_tally;
    cflt_pkg::cflt_tim1_s tim1;
    cflt_pkg::cflt_tim2_s tim2;
    cflt_pkg::cflt_tim3_s tim3;
    logic        config_mode;
    logic [7:0]  filt [NFILT][4];
    logic [7:0]  mask [NMASK][4];
    logic        ph_wr;
    logic [11:0] ph_addr;
    logic        wr_ok;
    logic        rd_ok;
    logic [31:0] next_rdata;

    // ================================================================
    // ahb-lite slave: zero wait, always okay
    // read data is registered in the address phase so it already stands
    // for the whole data phase; writes land one cycle later with hwdata
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign rd_ok     = HSEL & HTRANS[1] & HREADY & ~HWRITE;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ph_wr   <= 1'b0;
            ph_addr <= 12'h000;
        end else if (HREADY) begin
            ph_wr   <= HSEL & HTRANS[1] & HWRITE;
            ph_addr <= HADDR;
        end
    end
    assign wr_ok = ph_wr;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (HADDR)
            `CFLT_OFS_TALLY: next_rdata[7:0] = rx_error_tally; // RL1
            `CFLT_OFS_TIM1:  next_rdata[7:0] = tim1;
            `CFLT_OFS_TIM2:  next_rdata[7:0] = tim2;
            `CFLT_OFS_TIM3:  next_rdata[7:0] = tim3;
            `CFLT_OFS_CTRL:  next_rdata[0]   = config_mode;
            `CFLT_OFS_STAT:  next_rdata[3:0] =
                {ERROR_PASSIVE, ACCEPTANCE_HIT_CODE};
            default: begin
                for (int f = 0; f < NFILT; f++) begin
                    for (int b = 0; b < 4; b++) begin
                        if (HADDR == `CFLT_OFS_FILT_BASE
                                + 12'(f * 16 + b * 4))
                            next_rdata[7:0] = filt[f][b];
                    end
                end
                for (int m = 0; m < NMASK; m++) begin
                    for (int b = 0; b < 4; b++) begin
                        if (HADDR == `CFLT_OFS_MASK_BASE
                                + 12'(m * 16 + b * 4))
                            next_rdata[7:0] = mask[m][b];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)
            HRDATA <= 32'h0000_0000;
        else if (rd_ok)
            HRDATA <= next_rdata;
    end

    // ================================================================
    // timing and mode registers
    // the mode bit itself stays writable so software can always leave
    // configuration mode and come back to it
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tim1        <= '0; // RL20
            tim2        <= '0;
            tim3        <= '0;
            config_mode <= 1'b1;
        end else if (wr_ok) begin
            if (ph_addr == `CFLT_OFS_CTRL)
                config_mode <= HWDATA[0];
            // timing register writes outside configuration mode are dropped
            if (config_mode) begin // RL12
                if (ph_addr == `CFLT_OFS_TIM1)
                    tim1 <= HWDATA[7:0];
                if (ph_addr == `CFLT_OFS_TIM2)
                    tim2 <= HWDATA[7:0];
                if (ph_addr == `CFLT_OFS_TIM3)
                    tim3 <= HWDATA[7:0] & `CFLT_TIM3_KEEP;
            end
        end
    end

    // filter and mask bytes have no reset value
    // leaving them unreset saves a reset tree over many bytes; software
    // must load every filter and mask before relying on acceptance
    always_ff @(posedge CORE_CLK) begin
        if (wr_ok) begin
            for (int f = 0; f < NFILT; f++) begin
                for (int b = 0; b < 4; b++) begin
                    if (ph_addr == `CFLT_OFS_FILT_BASE + 12'(f * 16 + b * 4))
                        filt[f][b] <= (b == 1) ?
                            (HWDATA[7:0] & `CFLT_SIDL_KEEP_F) : // RL7
                            HWDATA[7:0];
                end
            end
            for (int m = 0; m < NMASK; m++) begin
                for (int b = 0; b < 4; b++) begin
                    if (ph_addr == `CFLT_OFS_MASK_BASE + 12'(m * 16 + b * 4))
                        mask[m][b] <= (b == 1) ?
                            (HWDATA[7:0] & `CFLT_SIDL_KEEP_M) : // RL9
                            HWDATA[7:0];
                end
            end
        end
    end

    // ================================================================
    // receive error tally
    // a large error outranks a plain error and a success in one cycle;
    // the tally saturates at both ends rather than wrapping
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)
            rx_error_tally <= 8'h00;
        else if (RX_ERR_BIG)
            rx_error_tally <= (rx_error_tally > 8'hf7) ? 8'hff :
                              rx_error_tally + 8'h08;
        else if (RX_ERR_INC && rx_error_tally != 8'hff)
            rx_error_tally <= rx_error_tally + 8'h01;
        else if (RX_OK_DEC && rx_error_tally != 8'h00)
            rx_error_tally <= rx_error_tally - 8'h01;
    end
    assign ERROR_PASSIVE   = rx_error_tally > `CFLT_PASSIVE_LIMIT; // RL1
    assign BUS_OFF_FROM_RX = 1'b0; // RL2

    // ================================================================
    // acceptance: filters mapped to masks 0,0,1,1,1,1
    // all filters compare in parallel; the lowest hitting number wins,
    // so the reported code never lands on a reserved value
    logic [28:0] f_id   [NFILT];
    logic [28:0] m_id   [NFILT];
    logic [NFILT-1:0] hit;
    always_comb begin
        for (int f = 0; f < NFILT; f++) begin
            int mi;
            mi = (f < 2) ? 0 : NMASK - 1;
            // high byte is id 28..21 ext or std 10..3
            f_id[f] = {filt[f][0], filt[f][1][7:5], // RL3 RL4
                       filt[f][1][1:0], filt[f][2], filt[f][3]}; // RL6
            m_id[f] = {mask[mi][0], mask[mi][1][7:5], // RL8
                       mask[mi][1][1:0], mask[mi][2], mask[mi][3]};
            if (filt[f][1][`CFLT_EXTSEL_BIT])
                hit[f] = ID_EXT && // RL5
                    (((ID_VALUE ^ f_id[f]) & m_id[f]) == 29'h0); // RL22
            else
                hit[f] = !ID_EXT &&
                    (((ID_VALUE[10:0] ^ f_id[f][28:18])
                      & m_id[f][28:18]) == 11'h0);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ACCEPTANCE_HIT_CODE <= 3'h0;
            ACCEPT_VALID        <= 1'b0;
        end else begin
            ACCEPT_VALID <= ID_VALID && (hit != '0);
            if (ID_VALID && hit != '0) begin
                for (int f = NFILT - 1; f >= 0; f--) begin
                    if (hit[f])
                        ACCEPTANCE_HIT_CODE <= 3'(f); // RL21
                end
            end
        end
    end

    // ================================================================
    // time quantum prescaler
    // the limit test is at-or-above, so shrinking the prescaler while the
    // counter is past the new limit never lets one quantum run long
    logic [6:0] tq_cnt;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)
            tq_cnt <= 7'h00;
        else if (tq_cnt >= {tim1.brp, 1'b1}) // RL10
            tq_cnt <= 7'h00;
        else
            tq_cnt <= tq_cnt + 7'h01;
    end
    assign TQ_TICK = tq_cnt >= {tim1.brp, 1'b1};
    assign RESYNC_JUMP_WIDTH = {1'b0, tim1.sjw} + 3'h1; // RL11

    // ================================================================
    // bit segment sequencer
    // limitation: no resynchronisation here, the jump width is only exported
    cflt_pkg::cflt_seg_e seg;
    logic [3:0] seg_q;
    logic [3:0] ph2_len;
    logic [3:0] ph1_len;
    assign ph1_len = {1'b0, tim2.ph1} + 4'h1; // RL15
    always_comb begin
        if (tim2.ph2_src)
            ph2_len = {1'b0, tim3.ph2} + 4'h1; // RL13 RL17
        else // RL18
            ph2_len = (ph1_len > `CFLT_IPT_TQ) ? ph1_len : `CFLT_IPT_TQ;
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            seg   <= cflt_pkg::CFLT_SYNC;
            seg_q <= 4'h0;
        end else if (TQ_TICK) begin
            unique case (seg) // RL23
                cflt_pkg::CFLT_SYNC: begin
                    seg   <= cflt_pkg::CFLT_PROP;
                    seg_q <= 4'h1;
                end
                cflt_pkg::CFLT_PROP: begin
                    if (seg_q >= {1'b0, tim2.prop} + 4'h1) begin // RL16
                        seg   <= cflt_pkg::CFLT_PH1;
                        seg_q <= 4'h1;
                    end else
                        seg_q <= seg_q + 4'h1;
                end
                cflt_pkg::CFLT_PH1: begin
                    if (seg_q >= ph1_len) begin
                        seg   <= cflt_pkg::CFLT_PH2;
                        seg_q <= 4'h1;
                    end else
                        seg_q <= seg_q + 4'h1;
                end
                cflt_pkg::CFLT_PH2: begin
                    if (seg_q >= ph2_len) begin
                        seg   <= cflt_pkg::CFLT_SYNC;
                        seg_q <= 4'h0;
                    end else
                        seg_q <= seg_q + 4'h1;
                end
            endcase
        end
    end
    assign SAMPLE_POINT = TQ_TICK && seg == cflt_pkg::CFLT_PH1
                          && seg_q >= ph1_len;

    // ================================================================
    // sampling: three samples on the last quanta, majority vote
    // the vote uses the two latest quantum samples and the level at the
    // sample point itself, so no extra delay is added to the result
    logic [2:0] samp;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            samp        <= 3'h7;
            SAMPLED_BIT <= 1'b1;
        end else begin
            if (TQ_TICK)
                samp <= {samp[1:0], RX_LINE};
            if (SAMPLE_POINT) begin
                if (tim2.triple) // RL14
                    SAMPLED_BIT <= (samp[0] & samp[1]) | (samp[0] & RX_LINE)
                                 | (samp[1] & RX_LINE);
                else
                    SAMPLED_BIT <= RX_LINE;
            end
        end
    end

    // ================================================================
    // wake line: optional glitch filter needs four stable clock cycles
    logic [1:0] wf_cnt;
    logic       wf_line;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wf_cnt  <= 2'h0;
            wf_line <= 1'b1;
        end else if (RX_LINE == wf_line)
            wf_cnt <= 2'h0;
        else if (wf_cnt == 2'h3) begin
            wf_line <= RX_LINE;
            wf_cnt  <= 2'h0;
        end else
            wf_cnt <= wf_cnt + 2'h1;
    end
    assign WAKE_LINE = tim3.wake_filt ? wf_line : RX_LINE; // RL19

endmodule
`default_nettype wire

// ==== bench/cflt_properties.sv ====
// concurrent checks on the ports of the can filter and timing core
`timescale 1ns/100ps
`default_nettype none
module cflt_props (
    input wire logic       CORE_CLK,
    input wire logic       RSTN,
    input wire logic       RX_ERR_INC,
    input wire logic       RX_ERR_BIG,
    input wire logic       RX_OK_DEC,
    input wire logic       ID_VALID,
    input wire logic       HREADYOUT,
    input wire logic       HRESP,
    input wire logic       ERROR_PASSIVE,
    input wire logic       BUS_OFF_FROM_RX,
    input wire logic [2:0] ACCEPTANCE_HIT_CODE,
    input wire logic       ACCEPT_VALID,
    input wire logic       TQ_TICK,
    input wire logic       SAMPLE_POINT,
    input wire logic       SAMPLED_BIT,
    input wire logic [2:0] RESYNC_JUMP_WIDTH
);
    // ==========================================================
    // properties
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    AST_PASSIVE_CAUSE: assert property (!$past(RX_ERR_INC | RX_ERR_BIG |
        RX_OK_DEC) |-> $stable(ERROR_PASSIVE)) else $error("passive moved");
    AST_NO_BUS_OFF: assert property (!BUS_OFF_FROM_RX)
        else $error("bus off from tally");
    AST_HIT_RANGE: assert property (ACCEPT_VALID |->
        ACCEPTANCE_HIT_CODE <= 3'h5) else $error("reserved hit code");
    AST_ACCEPT_CAUSE: assert property (ACCEPT_VALID |-> $past(ID_VALID))
        else $error("accept without id");
    AST_QUANTUM: assert property (TQ_TICK |=> !TQ_TICK ##[0:254] TQ_TICK)
        else $error("quantum length");
    AST_SAMPLE_HOLD: assert property (!$past(SAMPLE_POINT) |->
        $stable(SAMPLED_BIT)) else $error("sample off the point");
    AST_SAMPLE_EDGE: assert property (SAMPLE_POINT |-> TQ_TICK)
        else $error("sample point off a quantum edge");
    AST_JUMP: assert property (RESYNC_JUMP_WIDTH != 3'h0 &&
        RESYNC_JUMP_WIDTH <= 3'h4) else $error("jump width range");
    AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus response");
    COV_ACCEPT: cover property (ACCEPT_VALID);
    COV_PASSIVE: cover property ($rose(ERROR_PASSIVE));
    COV_SAMPLE: cover property (SAMPLE_POINT);
endmodule
bind cflt_core cflt_props u_props (.*);
`default_nettype wire

// ==== bench/cflt_node.sv ====
// far-side bus node that pulls the line dominant on request
`timescale 1ns/100ps
`default_nettype none
module cflt_node (
    input  wire logic       CORE_CLK,
    input  wire logic       go,
    input  wire logic [7:0] low_clks,
    output logic            rx_line
);
    // ==========================================================
    // line driver: recessive whenever no frame is sent
    initial rx_line = 1'b1;
    always @(posedge CORE_CLK) begin
        if (go) begin
            rx_line <= 1'b0;
            repeat (low_clks) @(posedge CORE_CLK);
            rx_line <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench of the can filter and timing core
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ==========================================================
    // signals, tasks and sequence
    logic        CORE_CLK = 0, RSTN = 0, HSEL = 1, HWRITE = 0, go = 0;
    logic [11:0] HADDR = 0;
    logic [1:0]  HTRANS = 0;
    logic [2:0]  HSIZE = 3'h2, ACCEPTANCE_HIT_CODE, RESYNC_JUMP_WIDTH;
    logic [31:0] HWDATA = 0, HRDATA, x;
    logic        HREADYOUT, HRESP, ERROR_PASSIVE, BUS_OFF_FROM_RX;
    logic        RX_ERR_INC = 0, RX_ERR_BIG = 0, RX_OK_DEC = 0;
    logic        ID_VALID = 0, ID_EXT = 0, ACCEPT_VALID, TQ_TICK;
    logic        SAMPLE_POINT, SAMPLED_BIT, WAKE_LINE, RX_LINE, HREADY;
    logic [28:0] ID_VALUE = 0;
    logic [7:0]  lowc = 0;
    int          errors = 0, checks = 0, cyc = 0, n;
    logic [27:0] rows [10] = '{28'h004ffff, 28'h008ffff, 28'h00cff47,
        28'h104ffeb, 28'h204ffe3, 28'h100a5a5, 28'h15c3c3c, 28'h2185a5a,
        28'h300ff00, 28'h000ff00};
    logic [7:0]  tr [8][5] = '{'{0, 0, 0, 0, 2}, '{8'h43, 0, 0, 0, 8},
        '{8'hbf, 0, 0, 0, 128}, '{8'hc0, 8'h8a, 3, 1, 20},
        '{8'hc0, 8'h0a, 7, 1, 16}, '{8'hc0, 8'h3a, 0, 1, 40},
        '{8'hc0, 8'h02, 0, 1, 14}, '{0, 8'h4a, 0, 1, 16}};
    assign HREADY = HREADYOUT;
    cflt_core dut_u (.*);
    cflt_node node_u (.CORE_CLK, .go, .low_clks(lowc), .rx_line(RX_LINE));
    always #20 CORE_CLK = ~CORE_CLK;
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // a hang must still end in the closing report
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        do @(posedge CORE_CLK); while (!HREADYOUT);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CORE_CLK); while (!HREADYOUT);
        rd = HRDATA;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, x);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0, x);
        cmp(x, {24'h0, e});
    endtask
    task automatic pulse(input int k);
        RX_ERR_INC <= (k == 0);
        RX_ERR_BIG <= (k == 1);
        RX_OK_DEC <= (k == 2);
        @(posedge CORE_CLK);
        {RX_ERR_INC, RX_ERR_BIG, RX_OK_DEC} <= 3'h0;
        @(posedge CORE_CLK);
    endtask
    function automatic logic [28:0] fid(input int f);
        return (f > 2) ? 29'h15550100 + 29'(f * 8) : 29'h100 + 29'(f * 8);
    endfunction
    task automatic send(input logic ext, input logic [28:0] id);
        ID_VALID <= 1'b1;
        ID_EXT <= ext;
        ID_VALUE <= id;
        @(posedge CORE_CLK);
        ID_VALID <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic gap(input logic sp);
        n = 0;
        do @(posedge CORE_CLK); while (!(sp ? SAMPLE_POINT : TQ_TICK));
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (!(sp ? SAMPLE_POINT : TQ_TICK));
    endtask
    task automatic glitch(input logic [7:0] len);
        lowc <= len;
        go <= 1'b1;
        @(posedge CORE_CLK);
        go <= 1'b0;
        n = 0;
        repeat (12) begin
            @(posedge CORE_CLK);
            n += int'(!WAKE_LINE);
        end
    endtask
    initial begin
        logic [31:0] fb;
        repeat (16) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][27:16], rows[i][15:8]);
            rd(rows[i][27:16], rows[i][7:0]);
        end
        wr(12'h010, 8'h00);
        wr(12'h004, 8'h12);
        rd(12'h004, 8'hff);
        wr(12'h010, 8'h01);
        foreach (tr[i]) begin
            for (int r = 0; r < 3; r++) wr(12'(4 * r + 4), tr[i][r]);
            gap(tr[i][3][0]);
            cmp(n, {24'h0, tr[i][4]});
            cmp(RESYNC_JUMP_WIDTH, 32'(tr[i][0][7:6]) + 1);
        end
        glitch(8'd60);
        cmp(n, 12);
        repeat (28) @(posedge CORE_CLK);
        cmp(SAMPLED_BIT, 0);
        repeat (60) @(posedge CORE_CLK);
        cmp(SAMPLED_BIT, 1);
        for (int m = 0; m < 8; m++) wr(12'h200 + 12'(4 * m), 8'hff);
        for (int f = 0; f < 6; f++) begin
            fb = (f > 2) ? {fid(f)[28:21], fid(f)[20:18], 3'b010, fid(f)[17:0]}
                         : {fid(f)[10:3], fid(f)[2:0], 21'h0};
            for (int b = 0; b < 4; b++)
                wr(12'h100 + 12'(16 * f + 4 * b), fb[31 - 8 * b -: 8]);
        end
        for (int f = 0; f < 6; f++) begin
            send(f > 2, fid(f));
            cmp({ACCEPT_VALID, ACCEPTANCE_HIT_CODE}, 8 + f);
        end
        send(1'b0, fid(3));
        cmp(ACCEPT_VALID, 0);
        send(1'b1, 29'h100);
        cmp(ACCEPT_VALID, 0);
        wr(12'h204, 8'h00);
        send(1'b0, 29'h107);
        cmp({ACCEPT_VALID, ACCEPTANCE_HIT_CODE}, 8);
        repeat (15) pulse(1);
        repeat (7) pulse(0);
        cmp(ERROR_PASSIVE, 0);
        pulse(0);
        cmp(ERROR_PASSIVE, 1);
        rd(12'h000, 8'h80);
        rd(12'h014, 8'h08);
        rd(12'h010, 8'h01);
        pulse(2);
        cmp(ERROR_PASSIVE, 0);
        wr(12'h00c, 8'h00);
        glitch(8'd2);
        cmp(n, 2);
        wr(12'h00c, 8'h40);
        glitch(8'd2);
        cmp(n, 0);
        RSTN <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 8'h00);
        rd(12'h010, 8'h01);
        print_verdict;
    end
endmodule
`default_nettype wire
